// ---- hw/mii_port_pkg.sv ----
// Shared constants and types for the controller-side link of the physical layer port.
// Assumes both ends run on one 125 MHz system clock.
package mii_port_pkg;

  // System and link clock rates
  localparam int SYS_CLK_KHZ   = 125000;
  localparam int FAST_LINK_KHZ = 25000;
  localparam int SLOW_LINK_KHZ = 2500;

  // Link clock dividers in system clock cycles
  localparam int DIV_W = 6;
  localparam logic [DIV_W-1:0] FAST_PERIOD = DIV_W'(SYS_CLK_KHZ / FAST_LINK_KHZ);
  localparam logic [DIV_W-1:0] SLOW_PERIOD = DIV_W'(SYS_CLK_KHZ / SLOW_LINK_KHZ);
  localparam logic [DIV_W-1:0] FAST_HIGH   = DIV_W'(SYS_CLK_KHZ / FAST_LINK_KHZ / 2);
  localparam logic [DIV_W-1:0] SLOW_HIGH   = DIV_W'(SYS_CLK_KHZ / SLOW_LINK_KHZ / 2);

  // Symbols and widths
  localparam int NIBBLE_W = 4;
  localparam int SYMBOL_W = 5;
  localparam logic [SYMBOL_W-1:0] HALT_SYMBOL = 5'h04;

  // Strap capture settle time after reset release
  localparam int STRAP_W = 5;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // Receive sequencing along the usual path
  typedef enum logic [1:0] {
    RX_IDLE    = 2'b00,
    RX_CARRIER = 2'b01,
    RX_DATA    = 2'b11
  } rx_state_t;

endpackage : mii_port_pkg

// ---- hw/mii_link_if.sv ----
// Link between the physical layer port and the controller.
// Resolves the port's output enables into wire levels seen by the controller.
// A floated line reads as pulled low.
`timescale 1ns/1ps
`default_nettype none
interface mii_link_if;
  // Controller to port
  logic       tx_en;
  logic [3:0] txd;
  logic       tx_er;
  logic       rx_enable_pin;
  // Port drive values and enables, low enable means driving
  logic       tx_clk_drv;
  logic       rx_clk_drv;
  logic [3:0] rxd_drv;
  logic       rx_dv_drv;
  logic       rx_er_drv;
  logic       crs_drv;
  logic       col_drv;
  logic       port_oe_n;
  logic       rx_oe_n;
  // Resolved levels
  wire        rx_off = port_oe_n | rx_oe_n;
  wire        tx_clk = ~port_oe_n & tx_clk_drv;
  wire        crs    = ~port_oe_n & crs_drv;
  wire        rx_clk = ~rx_off & rx_clk_drv;
  wire [3:0]  rxd    = rx_off ? 4'h0 : rxd_drv;
  wire        rx_dv  = ~rx_off & rx_dv_drv;
  wire        rx_er  = ~rx_off & rx_er_drv;
  wire        col    = ~rx_off & col_drv;

  modport phy (
    input  tx_en, txd, tx_er, rx_enable_pin,
    output tx_clk_drv, rx_clk_drv, rxd_drv, rx_dv_drv, rx_er_drv, crs_drv, col_drv,
    output port_oe_n, rx_oe_n
  );
  modport mac (
    output tx_en, txd, tx_er, rx_enable_pin,
    input  tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col
  );
endinterface : mii_link_if
`default_nettype wire

// ---- hw/phy_controller_port.sv ----
// Controller-side port of the physical layer: link clocks, transmit capture, receive output.
// Assumes the controller launches transmit pins from logic on this same clock.
`timescale 1ns/1ps
`default_nettype none
module phy_controller_port (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  mii_link_if.phy                        link,
  input  wire logic                      speed_10,
  input  wire logic                      coder_bypass,
  input  wire logic                      loopback_disable,
  input  wire logic                      pin_function_select,
  input  wire logic                      port_disable_wr,
  input  wire logic                      port_disable_value,
  input  wire logic [4:0]                management_address_straps,
  input  wire logic                      link_pass,
  input  wire logic                      collision_detect,
  input  wire logic                      line_rx_active,
  input  wire logic                      line_clock_recovered,
  input  wire logic [4:0]                line_rx_symbol,
  input  wire logic                      line_rx_error,
  output logic                           line_tx_valid,
  output logic                           line_tx_raw,
  output logic [4:0]                     line_tx_symbol,
  output logic                           line_tx_oe_n,
  output logic                           port_disabled,
  output logic                           five_bit_interface
);

  localparam int EXT_W = mii_port_pkg::STRAP_W + 1;

  // Outside pins: three flip-flops, change accepted when second and third agree
  logic [EXT_W-1:0] ext_s1;
  logic [EXT_W-1:0] ext_s2;
  logic [EXT_W-1:0] ext_s3;
  logic [EXT_W-1:0] ext_filt;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_s1 <= EXT_W'(1);
      ext_s2 <= EXT_W'(1);
      ext_s3 <= EXT_W'(1);
    end else begin
      ext_s1 <= {management_address_straps, link.rx_enable_pin};
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < EXT_W; gi++) begin : g_filt
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          ext_filt[gi] <= (gi == 0) ? 1'b1 : 1'b0;
        end else if (ext_s2[gi] == ext_s3[gi]) begin
          ext_filt[gi] <= ext_s3[gi];
        end
      end
    end
  endgenerate

  // Mode decode
  logic five_bit_active;
  assign five_bit_active = coder_bypass & ~speed_10;

  // Port disable with strap capture after reset release
  logic [2:0] strap_cnt;
  logic       strap_done;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_cnt     <= '0;
      strap_done    <= 1'b0;
      port_disabled <= 1'b1;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 3'h1;
      if (strap_cnt == mii_port_pkg::STRAP_SETTLE) begin
        strap_done    <= 1'b1;
        port_disabled <= &ext_filt[EXT_W-1:1];
      end
    end else if (port_disable_wr) begin
      port_disabled <= port_disable_value;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      five_bit_interface <= 1'b0;
    end else begin
      five_bit_interface <= five_bit_active;
    end
  end

  // Link clock dividers
  logic [mii_port_pkg::DIV_W-1:0] period;
  logic [mii_port_pkg::DIV_W-1:0] high_len;
  logic [mii_port_pkg::DIV_W-1:0] tx_cnt;
  logic [mii_port_pkg::DIV_W-1:0] rx_cnt;
  logic [mii_port_pkg::DIV_W-1:0] next_tx_cnt;
  logic [mii_port_pkg::DIV_W-1:0] next_rx_cnt;
  logic                           tx_rise;
  logic                           rx_fall;
  logic                           recovered_q;
  mii_port_pkg::rx_state_t        rx_state;
  mii_port_pkg::rx_state_t        next_rx_state;

  assign period   = speed_10 ? mii_port_pkg::SLOW_PERIOD : mii_port_pkg::FAST_PERIOD;
  assign high_len = speed_10 ? mii_port_pkg::SLOW_HIGH : mii_port_pkg::FAST_HIGH;

  always_comb begin
    tx_rise     = (tx_cnt >= period - 6'h1);
    next_tx_cnt = tx_rise ? '0 : tx_cnt + 6'h1;
    if (speed_10 && rx_state == mii_port_pkg::RX_CARRIER
        && line_clock_recovered && !recovered_q) begin
      next_rx_cnt = '0;
    end else if (speed_10 && rx_state == mii_port_pkg::RX_IDLE) begin
      next_rx_cnt = next_tx_cnt;
    end else if (!speed_10) begin
      next_rx_cnt = next_tx_cnt;
    end else begin
      next_rx_cnt = (rx_cnt >= period - 6'h1) ? '0 : rx_cnt + 6'h1;
    end
    rx_fall = (next_rx_cnt == high_len) && (rx_cnt != high_len);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_cnt          <= '1; // Wraps at once, first high phase whole
      rx_cnt          <= '0;
      recovered_q     <= 1'b0;
      link.tx_clk_drv <= 1'b0;
      link.rx_clk_drv <= 1'b0;
    end else begin
      tx_cnt          <= next_tx_cnt;
      rx_cnt          <= next_rx_cnt;
      recovered_q     <= line_clock_recovered;
      link.tx_clk_drv <= (next_tx_cnt < high_len);
      link.rx_clk_drv <= (next_rx_cnt < high_len);
    end
  end

  // Transmit capture on each link clock rise
  logic tx_framing;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      line_tx_valid  <= 1'b0;
      line_tx_raw    <= 1'b0;
      line_tx_symbol <= '0;
      tx_framing     <= 1'b0;
    end else if (tx_rise) begin
      tx_framing <= ~port_disabled & ~five_bit_active & link.tx_en;
      if (port_disabled) begin
        line_tx_valid  <= 1'b0;
        line_tx_raw    <= 1'b0;
        line_tx_symbol <= '0;
      end else if (five_bit_active) begin
        line_tx_valid  <= 1'b1;
        line_tx_raw    <= 1'b1;
        line_tx_symbol <= {link.tx_er, link.txd};
      end else if (link.tx_en) begin
        line_tx_valid <= 1'b1;
        if (link.tx_er && !speed_10) begin
          line_tx_raw    <= 1'b1;
          line_tx_symbol <= mii_port_pkg::HALT_SYMBOL;
        end else begin
          line_tx_raw    <= 1'b0;
          line_tx_symbol <= {1'b0, link.txd};
        end
      end else begin
        line_tx_valid  <= 1'b0;
        line_tx_raw    <= 1'b0;
        line_tx_symbol <= '0;
      end
    end
  end

  // Receive sequencing
  always_comb begin
    if (!link_pass || !line_rx_active || five_bit_active) begin
      next_rx_state = mii_port_pkg::RX_IDLE;
    end else begin
      case (rx_state)
        mii_port_pkg::RX_IDLE: begin
          next_rx_state = speed_10 ? mii_port_pkg::RX_CARRIER : mii_port_pkg::RX_DATA;
        end
        mii_port_pkg::RX_CARRIER: begin
          next_rx_state = recovered_q ? mii_port_pkg::RX_DATA : mii_port_pkg::RX_CARRIER;
        end
        mii_port_pkg::RX_DATA: begin
          next_rx_state = mii_port_pkg::RX_DATA;
        end
        default: begin
          next_rx_state = mii_port_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive outputs change on link clock falling edges
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_state       <= mii_port_pkg::RX_IDLE;
      link.crs_drv   <= 1'b0;
      link.rx_dv_drv <= 1'b0;
      link.rxd_drv   <= '0;
      link.rx_er_drv <= 1'b0;
    end else if (rx_fall) begin
      rx_state <= next_rx_state;
      if (five_bit_active) begin
        link.crs_drv   <= link_pass;
        link.rx_dv_drv <= 1'b0;
        link.rxd_drv   <= line_rx_symbol[3:0];
        link.rx_er_drv <= line_rx_symbol[4];
      end else begin
        link.crs_drv <= link_pass & ((next_rx_state != mii_port_pkg::RX_IDLE)
                        | (tx_framing & ~loopback_disable));
        link.rx_dv_drv <= (next_rx_state == mii_port_pkg::RX_DATA);
        link.rxd_drv   <= (next_rx_state == mii_port_pkg::RX_DATA)
                          ? line_rx_symbol[3:0] : 4'h0;
        link.rx_er_drv <= (next_rx_state == mii_port_pkg::RX_DATA)
                          & ~speed_10 & line_rx_error;
      end
    end
  end

  // Collision and output enables
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link.col_drv <= 1'b0;
    end else begin
      link.col_drv <= collision_detect & ~five_bit_active;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link.rx_oe_n   <= 1'b1;
      link.port_oe_n <= 1'b1;
      line_tx_oe_n   <= 1'b1;
    end else begin
      link.rx_oe_n   <= pin_function_select & ~ext_filt[0];
      link.port_oe_n <= port_disabled;
      line_tx_oe_n   <= port_disabled;
    end
  end

endmodule : phy_controller_port
`default_nettype wire

// ---- hw/mac_controller_port.sv ----
// Controller end of the link: drives transmit pins, samples receive pins.
// Assumes the port's link clocks are sampled from outside this clock's timing.
`timescale 1ns/1ps
`default_nettype none
module mac_controller_port (
  input  wire logic       clock,
  input  wire logic       rstn,
  mii_link_if.mac         link,
  input  wire logic       five_bit_mode,
  input  wire logic       rx_output_enable,
  input  wire logic       tx_valid,
  input  wire logic [4:0] tx_data,
  input  wire logic       tx_error,
  output logic            tx_taken,
  output logic            rx_valid,
  output logic [4:0]      rx_data,
  output logic            rx_error,
  output logic            carrier,
  output logic            collision
);

  localparam int IN_W = 10;

  // Pins: three flip-flops, change accepted when second and third agree
  logic [IN_W-1:0] in_s1;
  logic [IN_W-1:0] in_s2;
  logic [IN_W-1:0] in_s3;
  logic [IN_W-1:0] in_f;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      in_s1 <= '0;
      in_s2 <= '0;
      in_s3 <= '0;
    end else begin
      in_s1 <= {link.tx_clk, link.rx_clk, link.rxd, link.rx_dv, link.rx_er,
                link.crs, link.col};
      in_s2 <= in_s1;
      in_s3 <= in_s2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_filt
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          in_f[gi] <= 1'b0;
        end else if (in_s2[gi] == in_s3[gi]) begin
          in_f[gi] <= in_s3[gi];
        end
      end
    end
  endgenerate

  // Link clocks and their delayed copies for edge finding
  logic tx_clk_q;
  logic rx_clk_q;
  logic tx_clk_rise;
  logic rx_clk_rise;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end else begin
      tx_clk_q <= in_f[IN_W-1];
      rx_clk_q <= in_f[IN_W-2];
    end
  end

  assign tx_clk_rise = in_f[IN_W-1] & ~tx_clk_q;
  assign rx_clk_rise = in_f[IN_W-2] & ~rx_clk_q;

  // Transmit launch after each link clock rise
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link.tx_en <= 1'b0;
      link.txd   <= '0;
      link.tx_er <= 1'b0;
      tx_taken   <= 1'b0;
    end else begin
      tx_taken <= tx_clk_rise & tx_valid;
      if (tx_clk_rise) begin
        link.tx_en <= tx_valid & ~five_bit_mode;
        link.txd   <= tx_valid ? tx_data[3:0] : 4'h0;
        link.tx_er <= tx_valid & (five_bit_mode ? tx_data[4] : tx_error);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link.rx_enable_pin <= 1'b1;
    end else begin
      link.rx_enable_pin <= rx_output_enable;
    end
  end

  // Receive sampling on each receive clock rise
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx_data  <= '0;
      rx_error <= 1'b0;
    end else begin
      rx_valid <= rx_clk_rise & (in_f[3] | five_bit_mode);
      if (rx_clk_rise) begin
        rx_data  <= {five_bit_mode & in_f[2], in_f[7:4]};
        rx_error <= in_f[2] & ~five_bit_mode;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      carrier   <= 1'b0;
      collision <= 1'b0;
    end else begin
      carrier   <= in_f[1];
      collision <= in_f[0] & ~five_bit_mode;
    end
  end

endmodule : mac_controller_port
`default_nettype wire

// ---- bench/mii_link_sva.sv ----
// Checker for the link signals between port and controller.
// Assumes one system clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mii_link_sva (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       rx_enable_pin,
  input wire logic       tx_clk_drv,
  input wire logic       rx_clk_drv,
  input wire logic [3:0] rxd_drv,
  input wire logic       rx_dv_drv,
  input wire logic       rx_er_drv,
  input wire logic       crs_drv,
  input wire logic       rx_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [5:0] same_cnt;
  logic       last_clk;
  // Cycles since the transmit clock last changed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      same_cnt <= 6'h00;
      last_clk <= 1'b0;
    end else begin
      last_clk <= tx_clk_drv;
      same_cnt <= (tx_clk_drv != last_clk) ? 6'h00 : same_cnt + 6'h01;
    end
  end
  chk_clk_keeps_running: assert property (same_cnt <= 6'h18)
    else $error("transmit clock stopped");
  chk_clk_high_min: assert property ($rose(tx_clk_drv) |-> tx_clk_drv[*2])
    else $error("transmit clock high phase short");
  chk_clk_low_min: assert property ($fell(tx_clk_drv) |-> (!tx_clk_drv)[*3])
    else $error("transmit clock low phase short");
  chk_valid_has_carrier: assert property (rx_dv_drv |-> crs_drv)
    else $error("data valid without carrier");
  chk_idle_data_low: assert property (!crs_drv && !rx_dv_drv |-> rxd_drv == 4'h0)
    else $error("receive data not low while idle");
  chk_dv_on_fall: assert property ($rose(rx_dv_drv) |-> !rx_clk_drv)
    else $error("data valid rose off the falling point");
  chk_er_on_fall: assert property ($rose(rx_er_drv) |-> !rx_clk_drv)
    else $error("receive error rose off the falling point");
  chk_rxd_held_high: assert property (rx_clk_drv && $past(rx_clk_drv) |-> $stable(rxd_drv))
    else $error("receive data moved while clock high");
  chk_rx_enable_drives: assert property (rx_enable_pin[*8] |=> !rx_oe_n)
    else $error("receive outputs floated while enabled");
  cov_packet: cover property ($rose(rx_dv_drv));
  cov_error: cover property ($rose(rx_er_drv));
  cov_float: cover property ($rose(rx_oe_n));
endmodule : mii_link_sva
`default_nettype wire

// ---- bench/phy_mii_five_bit_controller_port_tb_top.sv ----
// Bench joining the port and the controller end over the link.
// Assumes the port makes both link clocks from the bench clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module phy_mii_five_bit_controller_port_tb_top;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic       speed_10 = 1'b0;
  logic       coder_bypass = 1'b0;
  logic       loopback_disable = 1'b0;
  logic       pin_function_select = 1'b0;
  logic       port_disable_wr = 1'b0;
  logic       port_disable_value = 1'b0;
  logic [4:0] straps = 5'h00;
  logic       link_pass = 1'b1;
  logic       collision_detect = 1'b0;
  logic       line_rx_active = 1'b0;
  logic       line_clock_recovered = 1'b0;
  logic [4:0] line_rx_symbol = 5'h00;
  logic       line_rx_error = 1'b0;
  logic       five_bit_mode = 1'b0;
  logic       rx_output_enable = 1'b1;
  logic       tx_valid = 1'b0;
  logic [4:0] tx_data = 5'h00;
  logic       tx_error = 1'b0;
  logic       line_tx_valid, line_tx_raw, line_tx_oe_n, port_disabled, five_bit_interface;
  logic [4:0] line_tx_symbol, rx_data;
  logic       rx_valid, rx_error, carrier, collision, tx_taken;
  int         err_total = 0;
  int         tests_run = 0;
  int         taken_cnt = 0;

  always #4 clock = ~clock;

  // Count transmit units handed to the port
  always @(posedge clock) begin
    if (tx_taken === 1'b1) begin
      taken_cnt++;
    end
  end

  mii_link_if link ();
  phy_controller_port phy_controller_port_inst (
    .clock(clock), .rstn(rstn), .link(link), .speed_10(speed_10),
    .coder_bypass(coder_bypass), .loopback_disable(loopback_disable),
    .pin_function_select(pin_function_select), .port_disable_wr(port_disable_wr),
    .port_disable_value(port_disable_value), .management_address_straps(straps),
    .link_pass(link_pass), .collision_detect(collision_detect),
    .line_rx_active(line_rx_active), .line_clock_recovered(line_clock_recovered),
    .line_rx_symbol(line_rx_symbol), .line_rx_error(line_rx_error),
    .line_tx_valid(line_tx_valid), .line_tx_raw(line_tx_raw),
    .line_tx_symbol(line_tx_symbol), .line_tx_oe_n(line_tx_oe_n),
    .port_disabled(port_disabled), .five_bit_interface(five_bit_interface));
  mac_controller_port mac_controller_port_inst (
    .clock(clock), .rstn(rstn), .link(link), .five_bit_mode(five_bit_mode),
    .rx_output_enable(rx_output_enable), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_error(tx_error), .tx_taken(tx_taken), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_error(rx_error), .carrier(carrier), .collision(collision));
  mii_link_sva mii_link_sva_inst (
    .clock(clock), .rstn(rstn), .rx_enable_pin(link.rx_enable_pin),
    .tx_clk_drv(link.tx_clk_drv), .rx_clk_drv(link.rx_clk_drv), .rxd_drv(link.rxd_drv),
    .rx_dv_drv(link.rx_dv_drv), .rx_er_drv(link.rx_er_drv), .crs_drv(link.crs_drv),
    .rx_oe_n(link.rx_oe_n));

  // Wait n cycles, land mid-cycle for checks
  task automatic go(input int n);
    repeat (n) @(negedge clock);
  endtask : go

  task automatic reset_dut(input logic [4:0] s);
    @(posedge clock);
    straps <= s;
    rstn <= 1'b0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    go(12);
  endtask : reset_dut

  task automatic write_disable(input logic v);
    @(posedge clock);
    port_disable_wr <= 1'b1;
    port_disable_value <= v;
    @(posedge clock);
    port_disable_wr <= 1'b0;
    go(4);
  endtask : write_disable

  // Wait for a received unit, bounded
  task automatic wait_rx;
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    `CHK(n < 400, 1'b1)
  endtask : wait_rx

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    end_of_test();
  end

  initial begin
    reset_dut(5'h1f);
    `CHK(port_disabled, 1'b1)
    `CHK(link.port_oe_n, 1'b1)
    `CHK(line_tx_oe_n, 1'b1)
    write_disable(1'b0);
    `CHK(port_disabled, 1'b0)
    reset_dut(5'h0f);
    `CHK(port_disabled, 1'b0)
    // Nibble transmit, halt substitution, carrier loopback
    @(posedge clock);
    tx_valid <= 1'b1;
    tx_data <= 5'h05;
    go(20);
    `CHK(line_tx_valid, 1'b1)
    `CHK(line_tx_raw, 1'b0)
    `CHK(line_tx_symbol, 5'h05)
    `CHK(carrier, 1'b1)
    `CHK((taken_cnt > 2) && (taken_cnt < 5), 1'b1)
    @(posedge clock);
    tx_error <= 1'b1;
    go(20);
    `CHK(line_tx_raw, 1'b1)
    `CHK(line_tx_symbol, mii_port_pkg::HALT_SYMBOL)
    @(posedge clock);
    tx_error <= 1'b0;
    loopback_disable <= 1'b1;
    go(20);
    `CHK(carrier, 1'b0)
    @(posedge clock);
    tx_valid <= 1'b0;
    go(20);
    `CHK(line_tx_valid, 1'b0)
    // Nibble receive with error and collision
    @(posedge clock);
    line_rx_symbol <= 5'h0c;
    line_rx_active <= 1'b1;
    wait_rx();
    `CHK(rx_data[3:0], 4'hc)
    `CHK(carrier, 1'b1)
    @(posedge clock);
    line_rx_error <= 1'b1;
    collision_detect <= 1'b1;
    go(20);
    `CHK(link.rx_er, 1'b1)
    `CHK(rx_error, 1'b1)
    `CHK(link.col, 1'b1)
    `CHK(collision, 1'b1)
    @(posedge clock);
    link_pass <= 1'b0;
    go(20);
    `CHK(link.crs, 1'b0)
    `CHK(link.rx_dv, 1'b0)
    `CHK(link.rxd, 4'h0)
    @(posedge clock);
    link_pass <= 1'b1;
    line_rx_active <= 1'b0;
    line_rx_error <= 1'b0;
    go(20);
    `CHK(link.rx_dv, 1'b0)
    `CHK(link.rxd, 4'h0)
    // Five-bit path both ways
    @(posedge clock);
    coder_bypass <= 1'b1;
    loopback_disable <= 1'b1;
    five_bit_mode <= 1'b1;
    tx_valid <= 1'b1;
    tx_data <= 5'h15;
    line_rx_symbol <= 5'h1a;
    go(20);
    `CHK(five_bit_interface, 1'b1)
    `CHK(line_tx_raw, 1'b1)
    `CHK(line_tx_symbol, 5'h15)
    `CHK(link.crs, 1'b1)
    `CHK(link.rx_dv, 1'b0)
    `CHK(link.col, 1'b0)
    wait_rx();
    `CHK(rx_data, 5'h1a)
    // Receive outputs floated by the shared pin
    @(posedge clock);
    pin_function_select <= 1'b1;
    rx_output_enable <= 1'b0;
    go(15);
    `CHK(link.rx_clk, 1'b0)
    `CHK(link.rxd, 4'h0)
    `CHK(link.rx_oe_n, 1'b1)
    `CHK(link.crs, 1'b1)
    @(posedge clock);
    rx_output_enable <= 1'b1;
    collision_detect <= 1'b0;
    go(15);
    `CHK(link.rx_dv, 1'b0)
    write_disable(1'b1);
    go(15);
    `CHK(port_disabled, 1'b1)
    `CHK(link.tx_clk, 1'b0)
    `CHK(link.port_oe_n, 1'b1)
    `CHK(line_tx_oe_n, 1'b1)
    `CHK(line_tx_valid, 1'b0)
    // Slow rate, bypass still set
    @(posedge clock);
    speed_10 <= 1'b1;
    five_bit_mode <= 1'b0;
    tx_error <= 1'b1;
    tx_data <= 5'h03;
    line_rx_symbol <= 5'h09;
    line_rx_error <= 1'b1;
    reset_dut(5'h00);
    go(200);
    `CHK(five_bit_interface, 1'b0)
    `CHK(line_tx_raw, 1'b0)
    `CHK(line_tx_symbol, 5'h03)
    @(posedge clock);
    line_rx_active <= 1'b1;
    go(200);
    `CHK(link.crs, 1'b1)
    `CHK(link.rx_dv, 1'b0)
    @(posedge clock);
    line_clock_recovered <= 1'b1;
    wait_rx();
    `CHK(rx_data[3:0], 4'h9)
    `CHK(link.rx_er, 1'b0)
    @(posedge clock);
    line_rx_active <= 1'b0;
    line_clock_recovered <= 1'b0;
    tx_valid <= 1'b0;
    go(200);
    `CHK(link.crs, 1'b0)
    `CHK(link.rxd, 4'h0)
    end_of_test();
  end
endmodule : phy_mii_five_bit_controller_port_tb_top
`default_nettype wire
